/* File: rtl/tpg_top.sv */
/*
  Time pulse generator with two outputs and edge time capture, configured
  over a classic Wishbone slave (32-bit data, byte address).
  Assumes all inputs are synchronous to clk; the time engine supplies the
  lock state, second marks, a disciplined microsecond tick and grid time.
*/
// The register addresses and the Wishbone register port are this design's own decisions.
// Behaviour
// - Two independent pulse outputs, each with own width and repetition rate.
// - Output toggles only while enabled; disabled output makes no pulses.
// - Rate type picks frequency or period meaning of rate value.
// - Width type picks microseconds or duty percentage of the period.
// - Unlocked rate used when locked alternative is off or not active.
// - With locked alternative set, locked rate and width apply once time valid.
// - Signed cable delay; positive value moves pulse earlier.
// - Signed user delay of each output's own; positive retards, negative advances, that output only.
// - Frequency lock derives rate from satellite-recovered frequency tick.
// - Second alignment aligns pulses to start of a whole grid second.
// - Polarity set means rising first edge, else falling.
// - Grid field: 0 UTC, 1 GPS, 2 GLONASS, 3 BeiDou, 4 Galileo.
// - Pulse width never exceeds the pulse period.
// - Steady rate in both lock states; alignment only while locked.
// - UTC grid withholds pulses until UTC parameters are received.
// - Automatic UTC variant: USNO, then SU, then NTSC, then European.
// - Input edges use output grid; UTC output implies GPS input.
// - Every report between pulses refers to the next pulse; last most accurate.
// - Edge capture timestamps against selectable grid or local time.
// - Channel A cable and user delays also correct captured timestamps.
`timescale 1ns/10ps
module tpg_top
  import tpg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        timeLocked,
  input  wire logic        utcParamsValid,
  input  wire logic        secondMark,
  input  wire logic        gnssUsTick,
  input  wire logic [31:0] gridTimeUs,
  input  wire logic [31:0] quantErrPs,
  input  wire logic        externalEventInput,
  output logic             pulseOutA,
  output logic             pulseOutB,
  output tpg_pkg::tpg_grid_t captureGrid,
  output tpg_pkg::tpg_utc_t  utcVariant
);
  import tpg_pkg::*;

  typedef struct packed {
    logic [1:0][6:0][31:0] cfg;
    logic [2:0]            utcSel;
    logic [3:0]            gnssEn;
    logic [2:0]            capRef;
    logic                  riseNew;
    logic                  fallNew;
    logic [7:0]            edgeCnt;
    logic [31:0]           riseTime;
    logic [31:0]           fallTime;
    logic [1:0][31:0]      report;
    logic [31:0]           reportQe;
    logic [5:0]            div;
    logic                  localTick;
    logic [31:0]           localUs;
    logic                  evPrev;
    logic [2:0]            capGrid;
    logic [2:0]            utcEff;
    logic                  ack;
    logic [31:0]           rdat;
  } tpg_state_t;

  tpg_state_t s_reg, s_next;

  logic [1:0]        chOut;
  logic [1:0][31:0]  chRemain;
  logic [1:0]        chEn, chFreq, chPct, chPol, chSec;
  logic [1:0][31:0]  chRate, chWidth, chShift;
  logic [1:0]        chTick;
  logic [31:0]       wmask;
  logic              wbReq;
  logic [2:0]        idx;
  logic              isGlobal;
  logic              chSel;
  logic [31:0]       rawStamp;
  logic [2:0]        gridA;

  // Bus decode
  assign wbReq    = wb_cyc_i && wb_stb_i && !s_reg.ack;
  assign idx      = wb_adr_i[4:2];
  assign isGlobal = wb_adr_i[6];
  assign chSel    = wb_adr_i[5];
  assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign gridA    = s_reg.cfg[0][IDX_CTRL][C_GRID +: 3];

  // Per-channel setting selection
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      logic [31:0] ctl;
      logic        useLk;
      ctl        = s_reg.cfg[c][IDX_CTRL];
      useLk      = ctl[C_LOCKED] && timeLocked;
      chRate[c]  = useLk ? s_reg.cfg[c][IDX_RATE_LK] : s_reg.cfg[c][IDX_RATE];
      chWidth[c] = useLk ? s_reg.cfg[c][IDX_WIDTH_LK] : s_reg.cfg[c][IDX_WIDTH];
      chFreq[c]  = ctl[C_FREQ];
      chPct[c]   = ctl[C_PCT];
      chPol[c]   = ctl[C_POL];
      chEn[c]    = ctl[C_EN] &&
                   !(ctl[C_GRID +: 3] == GRID_UTC && !utcParamsValid);
      chSec[c]   = secondMark && ctl[C_ALIGN] && timeLocked;
      chShift[c] = s_reg.cfg[c][IDX_USER] - s_reg.cfg[c][IDX_CABLE];
      chTick[c]  = ctl[C_FLOCK] ? gnssUsTick : s_reg.localTick;
    end
  end

  // Two pulse channels
  for (genvar g = 0; g < 2; g++) begin : gen_ch
    tpg_channel u_ch (
      .clk         (clk),
      .rst         (rst),
      .usTick      (chTick[g]),
      .enable      (chEn[g]),
      .rateIsFreq  (chFreq[g]),
      .widthIsPct  (chPct[g]),
      .rate        (chRate[g]),
      .width       (chWidth[g]),
      .polarity    (chPol[g]),
      .secMark     (chSec[g]),
      .shiftUs     (chShift[g]),
      .pulseOut    (chOut[g]),
      .remainPhase (chRemain[g])
    );
  end

  // Captured stamp source
  assign rawStamp = (s_reg.capGrid == GRID_LOCAL) ? s_reg.localUs : gridTimeUs;

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.ack       = wbReq;
    s_next.localTick = 1'b0;
    // Local microsecond time base
    if (s_reg.div == 6'(CYC_PER_US - 1)) begin
      s_next.div       = 6'h00;
      s_next.localTick = 1'b1;
      s_next.localUs   = s_reg.localUs + 32'h0000_0001;
    end else begin
      s_next.div = s_reg.div + 6'h01;
    end
    // Automatic UTC variant in preference order
    if (s_reg.utcSel != UTC_AUTO) begin
      s_next.utcEff = s_reg.utcSel;
    end else if (s_reg.gnssEn[0]) begin
      s_next.utcEff = UTC_USNO;
    end else if (s_reg.gnssEn[1]) begin
      s_next.utcEff = UTC_SU;
    end else if (s_reg.gnssEn[2]) begin
      s_next.utcEff = UTC_NTSC;
    end else if (s_reg.gnssEn[3]) begin
      s_next.utcEff = UTC_EU;
    end else begin
      s_next.utcEff = UTC_AUTO;
    end
    // Capture grid: follow output A grid, UTC output means GPS input
    if (s_reg.capRef == GRID_FOLLOW) begin
      s_next.capGrid = (gridA == GRID_UTC) ? GRID_GPS : gridA;
    end else begin
      s_next.capGrid = s_reg.capRef;
    end
    // Next-pulse reports once per second
    if (secondMark) begin
      s_next.report   = chRemain;
      s_next.reportQe = quantErrPs;
    end
    // Register writes; clears lose against a same-cycle capture
    if (wbReq && wb_we_i) begin
      if (wb_adr_i[7]) begin
        // Upper half of the map is empty: writes there are dropped
      end else if (!isGlobal) begin
        if (idx != 3'h7) begin
          s_next.cfg[chSel][idx] = (s_reg.cfg[chSel][idx] & ~wmask) | (wb_dat_i & wmask);
        end
      end else if (!chSel) begin
        case (idx)
          GIDX_UTC: begin
            if (wb_sel_i[0]) begin
              s_next.utcSel = wb_dat_i[2:0];
            end
            if (wb_sel_i[1]) begin
              s_next.gnssEn = wb_dat_i[11:8];
            end
          end
          GIDX_CAPCFG: begin
            if (wb_sel_i[0]) begin
              s_next.capRef = wb_dat_i[2:0];
            end
          end
          GIDX_CAPFLG: begin
            if (wb_sel_i[0] && wb_dat_i[0]) begin
              s_next.riseNew = 1'b0;
            end
            if (wb_sel_i[0] && wb_dat_i[1]) begin
              s_next.fallNew = 1'b0;
            end
            if (wb_sel_i[1] && wb_dat_i[15]) begin
              s_next.edgeCnt = 8'h00;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Edge capture with delay compensation
    s_next.evPrev = externalEventInput;
    if (externalEventInput != s_reg.evPrev) begin
      s_next.edgeCnt = s_reg.edgeCnt + 8'h01;
      if (externalEventInput) begin
        s_next.riseTime = rawStamp + s_reg.cfg[0][IDX_CABLE] - s_reg.cfg[0][IDX_USER];
        s_next.riseNew  = 1'b1;
      end else begin
        s_next.fallTime = rawStamp + s_reg.cfg[0][IDX_CABLE] - s_reg.cfg[0][IDX_USER];
        s_next.fallNew  = 1'b1;
      end
    end
    // Register reads
    s_next.rdat = 32'h0000_0000;
    if (wbReq && !wb_we_i) begin
      if (wb_adr_i[7]) begin
        // Upper half of the map is empty: reads there return zero
      end else if (!isGlobal) begin
        if (idx != 3'h7) begin
          s_next.rdat = s_reg.cfg[chSel][idx];
        end
      end else if (!chSel) begin
        case (idx)
          GIDX_STATUS: s_next.rdat = {26'h0, chOut, utcParamsValid, timeLocked, chEn};
          GIDX_UTC:    s_next.rdat = {20'h0, s_reg.gnssEn, 1'b0, s_reg.utcEff, 1'b0, s_reg.utcSel};
          GIDX_CAPCFG: s_next.rdat = {26'h0, s_reg.capGrid, s_reg.capRef};
          GIDX_CAPFLG: s_next.rdat = {16'h0, s_reg.edgeCnt, 6'h0, s_reg.fallNew, s_reg.riseNew};
          GIDX_RISE:   s_next.rdat = s_reg.riseTime;
          GIDX_FALL:   s_next.rdat = s_reg.fallTime;
          GIDX_REPA:   s_next.rdat = s_reg.report[0];
          GIDX_REPB:   s_next.rdat = s_reg.report[1];
          default:     s_next.rdat = 32'h0000_0000;
        endcase
      end else if ({wb_adr_i[7:2], 2'b00} == ADR_QERR) begin
        s_next.rdat = s_reg.reportQe;
      end
    end
  end

  // State register with reset values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      for (int c = 0; c < 2; c++) begin
        s_reg.cfg[c][IDX_CTRL]     <= RST_CTRL;
        s_reg.cfg[c][IDX_RATE]     <= RST_RATE;
        s_reg.cfg[c][IDX_WIDTH]    <= RST_WIDTH;
        s_reg.cfg[c][IDX_RATE_LK]  <= RST_RATE;
        s_reg.cfg[c][IDX_WIDTH_LK] <= RST_WIDTH;
      end
      s_reg.capRef <= RST_CAPREF;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign wb_dat_o    = s_reg.rdat;
  assign wb_ack_o    = s_reg.ack;
  assign pulseOutA   = chOut[0];
  assign pulseOutB   = chOut[1];
  assign captureGrid = tpg_grid_t'(s_reg.capGrid);
  assign utcVariant  = tpg_utc_t'(s_reg.utcEff);
endmodule : tpg_top

/* File: rtl/tpg_pkg.sv */
/*
  Shared constants of the time pulse generator: register map, control fields,
  reset values and timing counts. Assumes a 40 MHz system clock.
*/
package tpg_pkg;
  // Timing
  localparam int CLK_NS       = 25;
  localparam int US_NS        = 1000;
  localparam int CYC_PER_US   = US_NS / CLK_NS;
  localparam logic [31:0] US_PER_SEC = 32'h000F_4240;
  localparam logic [31:0] PCT_FULL   = 32'h0000_0064;
  // Per-channel word index (channel base: byte address bit 5)
  localparam logic [2:0] IDX_CTRL    = 3'h0;
  localparam logic [2:0] IDX_RATE    = 3'h1;
  localparam logic [2:0] IDX_WIDTH   = 3'h2;
  localparam logic [2:0] IDX_RATE_LK = 3'h3;
  localparam logic [2:0] IDX_WIDTH_LK= 3'h4;
  localparam logic [2:0] IDX_CABLE   = 3'h5;
  localparam logic [2:0] IDX_USER    = 3'h6;
  // Global word index (byte address 0x40 + 4*index)
  localparam logic [2:0] GIDX_STATUS = 3'h0;
  localparam logic [2:0] GIDX_UTC    = 3'h1;
  localparam logic [2:0] GIDX_CAPCFG = 3'h2;
  localparam logic [2:0] GIDX_CAPFLG = 3'h3;
  localparam logic [2:0] GIDX_RISE   = 3'h4;
  localparam logic [2:0] GIDX_FALL   = 3'h5;
  localparam logic [2:0] GIDX_REPA   = 3'h6;
  localparam logic [2:0] GIDX_REPB   = 3'h7;
  localparam logic [7:0] ADR_QERR    = 8'h60;
  // Control fields
  localparam int C_EN     = 0;
  localparam int C_FREQ   = 1;
  localparam int C_PCT    = 2;
  localparam int C_LOCKED = 3;
  localparam int C_FLOCK  = 4;
  localparam int C_ALIGN  = 5;
  localparam int C_POL    = 6;
  localparam int C_GRID   = 8;
  // Reset values
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_RATE  = 32'h000F_4240;
  localparam logic [31:0] RST_WIDTH = 32'h0001_86A0;
  localparam logic [2:0]  RST_CAPREF= 3'h7;
  // Time grids and capture references
  typedef enum logic [2:0] {
    GRID_UTC = 3'b000, GRID_GPS = 3'b001, GRID_GLO = 3'b010,
    GRID_BDS = 3'b011, GRID_GAL = 3'b100, GRID_LOCAL = 3'b101,
    GRID_FOLLOW = 3'b111
  } tpg_grid_t;
  // UTC variants
  typedef enum logic [2:0] {
    UTC_AUTO = 3'b000, UTC_USNO = 3'b001, UTC_SU = 3'b010,
    UTC_NTSC = 3'b011, UTC_EU = 3'b100
  } tpg_utc_t;
endpackage : tpg_pkg

/* File: rtl/tpg_channel.sv */
/*
  One pulse output channel: rate/phase counter, width compare, polarity and
  second realignment with compensation shift.
  Assumes usTick is a one-cycle enable at 1 MHz and secMark is already gated
  by time lock and the alignment setting.
*/
`timescale 1ns/10ps
module tpg_channel
  import tpg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        usTick,
  input  wire logic        enable,
  input  wire logic        rateIsFreq,
  input  wire logic        widthIsPct,
  input  wire logic [31:0] rate,
  input  wire logic [31:0] width,
  input  wire logic        polarity,
  input  wire logic        secMark,
  input  wire logic [31:0] shiftUs,
  output logic             pulseOut,
  output logic [31:0]      remainPhase
);
  typedef struct packed {
    logic [31:0] pos;
    logic [31:0] elapsed;
    logic [31:0] dly;
    logic        dlyRun;
    logic        out;
    logic [31:0] remain;
  } tpg_ch_t;

  tpg_ch_t s_reg, s_next;
  logic [31:0] step, span;
  logic [32:0] sum;
  logic        active;
  logic        run;

  // Step and span: period counts microseconds, frequency accumulates Hz
  assign step = rateIsFreq ? rate : 32'h0000_0001;
  assign span = rateIsFreq ? US_PER_SEC : rate;
  assign sum  = {1'b0, s_reg.pos} + {1'b0, step};
  assign run  = enable && (rate != 32'h0000_0000);

  // Next state
  always_comb begin
    s_next = s_reg;
    active = widthIsPct ?
             (({32'h0000_0000, s_reg.pos} * 64'(PCT_FULL)) < ({32'h0000_0000, width} * 64'(span))) :
             (s_reg.elapsed < width);
    if (secMark) begin
      s_next.dly    = US_PER_SEC + shiftUs;
      s_next.dlyRun = 1'b1;
    end
    if (usTick) begin
      if (!run) begin
        s_next.pos     = 32'h0000_0000;
        s_next.elapsed = 32'h0000_0000;
      end else if (s_reg.dlyRun && s_reg.dly <= 32'h0000_0001) begin
        s_next.pos     = 32'h0000_0000;
        s_next.elapsed = 32'h0000_0000;
        s_next.dlyRun  = 1'b0;
      end else if (sum >= {1'b0, span}) begin
        s_next.pos     = rateIsFreq ? 32'(sum - {1'b0, span}) : 32'h0000_0000;
        s_next.elapsed = 32'h0000_0000;
      end else begin
        s_next.pos     = sum[31:0];
        s_next.elapsed = s_reg.elapsed + 32'h0000_0001;
      end
      if (s_reg.dlyRun && !secMark && s_reg.dly > 32'h0000_0001) begin
        s_next.dly = s_reg.dly - 32'h0000_0001;
      end
    end
    s_next.remain = span - s_reg.pos;
    s_next.out    = run ? (active ~^ polarity) : ~polarity;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pulseOut    = s_reg.out;
  assign remainPhase = s_reg.remain;
endmodule : tpg_channel

/* File: verification/tpg_time_src.sv */
/*
  Timing source model: microsecond tick, second mark, grid time,
  quantization error and the external event pin.
  Assumes a 40 MHz clk; markReq is driven by the bench.
*/
`timescale 1ns/10ps
module tpg_time_src #(
  parameter int SEC_US = 50
) (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   markReq,
  output logic        secondMark,
  output logic        gnssUsTick,
  output logic [31:0] gridTimeUs,
  output logic [31:0] quantErrPs,
  output logic        externalEventInput
);
  logic [5:0] div_reg;
  // Recovered tick every 41 clocks, slower than the local 40, so frequency lock shows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= 6'h00;
      gnssUsTick <= 1'b0;
      secondMark <= 1'b0;
      gridTimeUs <= 32'h0000_0000;
      quantErrPs <= 32'h0000_0000;
      externalEventInput <= 1'b0;
    end else begin
      div_reg <= (div_reg == 6'd40) ? 6'h00 : div_reg + 6'h01;
      gnssUsTick <= (div_reg == 6'd40);
      if (div_reg == 6'd40) begin
        gridTimeUs <= gridTimeUs + 32'h0000_0001;
      end
      secondMark <= (div_reg == 6'd40) && (gridTimeUs % SEC_US == 0);
      quantErrPs <= quantErrPs + 32'h0000_0003;
      externalEventInput <= markReq;
    end
  end
endmodule : tpg_time_src

/* File: verification/tpg_asserts.sv */
/*
  Bus and output checks on the time pulse generator top.
  Assumes the classic Wishbone master of the bench.
*/
`timescale 1ns/10ps
module tpg_checker
  import tpg_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire tpg_pkg::tpg_grid_t captureGrid,
  input wire tpg_pkg::tpg_utc_t  utcVariant
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  hole_a_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h1C) |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  hole_hi_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h60) |-> wb_dat_o == 32'h0000_0000)
    else $error("high unmapped read not zero");
  utc_range_a: assert property (utcVariant <= UTC_EU)
    else $error("utc variant out of range");
  grid_range_a: assert property (captureGrid <= GRID_LOCAL)
    else $error("capture grid out of range");
endmodule : tpg_checker

bind tpg_top tpg_checker tpg_checker_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .captureGrid(captureGrid), .utcVariant(utcVariant));

/* File: verification/tpg_top_tb_top.sv */
/*
  Testbench: register accesses over Wishbone, pulse length checks.
  Assumes the time source model drives the timing inputs.
*/
`timescale 1ns/10ps
module tpg_top_tb_top;
  import tpg_pkg::*;
  logic        clk, rst, cyc, stb, we, timeLocked, utcParamsValid, markReq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, wb_dat_o, gridTimeUs, quantErrPs, t;
  logic        wb_ack_o, secondMark, gnssUsTick, externalEventInput, pulseOutA, pulseOutB;
  logic [1:0]  po;
  tpg_grid_t   captureGrid;
  tpg_utc_t    utcVariant;
  int          errors, samples_checked, cycles, n;
  logic [31:0] pc [5][5] = '{
    '{32'h0000_0141, 32'h0000_000A, 32'h0000_0003, 32'h0000_0001, 32'h0000_0078},
    '{32'h0000_0141, 32'h0000_000A, 32'h0000_0003, 32'h0000_0000, 32'h0000_0118},
    '{32'h0000_0145, 32'h0000_000A, 32'h0000_0032, 32'h0000_0001, 32'h0000_00C8},
    '{32'h0000_0143, 32'h0001_86A0, 32'h0000_0003, 32'h0000_0001, 32'h0000_0078},
    '{32'h0000_0101, 32'h0000_000A, 32'h0000_0003, 32'h0000_0000, 32'h0000_0078}};
  logic [3:0]  en [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'hE, 4'hC};
  logic [2:0]  ex [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h2, 3'h3};
  assign po = {pulseOutB, pulseOutA};

  tpg_top tpg_top_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timeLocked(timeLocked),
    .utcParamsValid(utcParamsValid), .secondMark(secondMark), .gnssUsTick(gnssUsTick),
    .gridTimeUs(gridTimeUs), .quantErrPs(quantErrPs), .externalEventInput(externalEventInput),
    .pulseOutA(pulseOutA), .pulseOutB(pulseOutB), .captureGrid(captureGrid), .utcVariant(utcVariant));
  tpg_time_src tpg_time_src_i (.clk(clk), .rst(rst), .markReq(markReq), .secondMark(secondMark),
    .gnssUsTick(gnssUsTick), .gridTimeUs(gridTimeUs), .quantErrPs(quantErrPs),
    .externalEventInput(externalEventInput));

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle: hold until ack is sampled, then release
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wbx

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wbx(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask : rdchk

  task automatic wrwait(input logic [7:0] a, input logic [31:0] d);
    wbx(1'b1, a, d);
    repeat (3) @(posedge clk);
  endtask : wrwait

  // Clock cycles spent at level lv in one whole phase
  task automatic len(input int c, input logic lv);
    wait (po[c] === ~lv);
    wait (po[c] === lv);
    n = 0;
    while (po[c] === lv) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : len

  task automatic steady(input logic lv);
    repeat (20) begin
      repeat (10) @(posedge clk);
      chk({31'h0, po[0]}, {31'h0, lv});
    end
  endtask : steady

  // Clock and hang limit
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    {rst, cyc, stb, we, timeLocked, markReq} = 6'b100000;
    utcParamsValid = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h00, RST_CTRL);
    rdchk(8'h04, RST_RATE);
    rdchk(8'h28, RST_WIDTH);
    rdchk(8'h1C, 32'h0000_0000);
    rdchk(8'h64, 32'h0000_0000);
    // Channel B runs alongside every A case
    wbx(1'b1, 8'h24, 32'h0000_0014);
    wbx(1'b1, 8'h28, 32'h0000_0005);
    wbx(1'b1, 8'h20, 32'h0000_0141);
    for (int i = 0; i < 5; i++) begin
      wbx(1'b1, 8'h04, pc[i][1]);
      wbx(1'b1, 8'h08, pc[i][2]);
      wbx(1'b1, 8'h00, pc[i][0]);
      len(0, pc[i][3][0]);
      len(0, pc[i][3][0]);
      chk(32'(n), pc[i][4]);
    end
    len(1, 1'b1);
    chk(32'(n), 32'h0000_00C8);
    wbx(1'b1, 8'h0C, 32'h0000_0014);
    wbx(1'b1, 8'h10, 32'h0000_0005);
    wbx(1'b1, 8'h00, 32'h0000_0149);
    len(0, 1'b1);
    len(0, 1'b1);
    chk(32'(n), 32'h0000_0078);
    timeLocked <= 1'b1;
    len(0, 1'b1);
    len(0, 1'b1);
    chk(32'(n), 32'h0000_00C8);
    timeLocked <= 1'b0;
    wrwait(8'h00, 32'h0000_0140);
    steady(1'b0);
    wrwait(8'h00, 32'h0000_0100);
    steady(1'b1);
    wrwait(8'h00, 32'h0000_0041);
    steady(1'b0);
    chk(32'(captureGrid), 32'h0000_0001);
    utcParamsValid <= 1'b1;
    len(0, 1'b1);
    len(0, 1'b1);
    chk(32'(n), 32'h0000_0078);
    // Frequency lock: recovered tick of 41 clocks stretches the 3 us pulse
    wrwait(8'h00, 32'h0000_0151);
    len(0, 1'b1);
    len(0, 1'b1);
    chk(32'(n), 32'h0000_007B);
    wrwait(8'h00, 32'h0000_0441);
    chk(32'(captureGrid), 32'h0000_0004);
    wrwait(8'h48, 32'h0000_0005);
    chk(32'(captureGrid), 32'h0000_0005);
    wrwait(8'h48, 32'h0000_0002);
    chk(32'(captureGrid), 32'h0000_0002);
    for (int i = 0; i < 7; i++) begin
      wrwait(8'h44, {20'h0_0000, en[i], 8'h00});
      chk(32'(utcVariant), {29'h0, ex[i]});
    end
    // Edge capture with cable 5 and user 2
    wbx(1'b1, 8'h14, 32'h0000_0005);
    wbx(1'b1, 8'h18, 32'h0000_0002);
    wbx(1'b1, 8'h4C, 32'h0000_8003);
    @(posedge gnssUsTick);
    #1;
    t = gridTimeUs;
    @(posedge clk);
    markReq <= 1'b1;
    repeat (8) @(posedge clk);
    rdchk(8'h4C, 32'h0000_0101);
    rdchk(8'h50, t + 32'h0000_0003);
    markReq <= 1'b0;
    repeat (8) @(posedge clk);
    rdchk(8'h4C, 32'h0000_0203);
    wbx(1'b1, 8'h4C, 32'h0000_8003);
    rdchk(8'h4C, 32'h0000_0000);
    conclude();
  end
endmodule : tpg_top_tb_top
